// file: core/psg_codec_end.sv
// codec end: slot counters, slot assignment, gain and echo-cancel settings
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
module psg_codec_end
  import psg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  psg_link_if.codec link,
  input wire logic [7:0] tx_sample,
  output logic tx_sample_taken,
  output logic [7:0] rx_sample,
  output logic rx_sample_valid,
  output logic nondelayed_timing,
  output logic [7:0] tx_level_code,
  output logic tx_muted,
  output logic [7:0] rx_level_code,
  output logic analog_rx_off,
  output logic echo_enable,
  output logic echo_phase_noninv,
  output logic high_band_insert,
  output logic [4:0] cancel_attenuation,
  output logic low_band_enable,
  output logic low_band_first_order,
  output logic [6:0] low_band_pz
);
  typedef struct packed {
    logic [7:0] p0, p1, p2, lvl;
    logic nd;
    psg_cnt_t txc, rxc;
    psg_asg_t tx_cur, tx_new, rx_cur, rx_new;
    logic [1:0] tx_wait, rx_wait;
    logic [15:0] ins;
    logic [4:0] nbit;
    logic [7:0] txg, rxg, hyb, low;
    logic [4:0] att;
    logic txg_off, rxg_off, low_on;
    logic [7:0] txsh, rxsh, rxb;
    logic rxv, taken;
    logic dx0, dx0_oe, dx1, dx1_oe;
  } psg_codec_st_t;

  psg_codec_st_t r, n;
  logic [7:0] pins;
  logic b_rise, b_fall, c_rise, s_rise, s_fall, mk_tx, mk_rx, bitv;
  logic [5:0] tx_slot, rx_slot;

  // one bit-clock rise of a slot counter
  function automatic psg_cnt_t cnt_step(input psg_cnt_t c, input logic mk, input logic nd);
    psg_cnt_t o;
    o = c;
    o.mk = mk;
    if (c.pend) begin
      o.act = 1'b1; // delayed: slot 0 one bit clock after the marker
      o.pend = 1'b0;
      o.bitc = 3'h0;
      o.slot = 6'h00;
    end else if (c.act) begin
      if (c.bitc == SLOT_LAST_BIT) begin
        o.bitc = 3'h0;
        if (c.slot == SLOT_LAST) begin
          o.act = 1'b0; // frame ends after slot 63
        end else begin
          o.slot = c.slot + 6'h01;
        end
      end else begin
        o.bitc = c.bitc + 3'h1;
      end
    end
    // delayed markers overlap the last bit of a full frame, so that bit still counts
    if (mk && !c.mk && nd) begin
      o.act = 1'b1; // non-delayed: slot 0 starts at this edge
      o.pend = 1'b0;
      o.bitc = 3'h0;
      o.slot = 6'h00;
    end else if (mk && !c.mk) begin
      o.pend = 1'b1;
    end
    return o;
  endfunction : cnt_step

  // second byte of an assignment
  function automatic psg_asg_t to_asg(input logic [7:0] b);
    psg_asg_t a;
    a.en = b[ASG_EN];
    a.port = b[ASG_PORT] & DUAL_PORT;
    a.slot = b[5:0];
    return a;
  endfunction : to_asg

  assign pins = {link.ctrl_data, link.ctrl_sel_n, link.ctrl_clk, link.rx_pcm_in_second,
                 link.rx_pcm_in_first, link.rx_frame_marker, link.tx_frame_marker, link.bclk};

  // next state
  always_comb begin
    n = r;
    n.rxv = 1'b0;
    n.taken = 1'b0;
    n.p0 = pins;
    n.p1 = r.p0;
    n.p2 = r.p1;
    n.lvl = (r.p1 & r.p2) | (r.lvl & (r.p1 ^ r.p2));
    b_rise = n.lvl[PIN_BCLK] & ~r.lvl[PIN_BCLK];
    b_fall = ~n.lvl[PIN_BCLK] & r.lvl[PIN_BCLK];
    c_rise = n.lvl[PIN_CCLK] & ~r.lvl[PIN_CCLK];
    s_rise = n.lvl[PIN_CSN] & ~r.lvl[PIN_CSN];
    s_fall = ~n.lvl[PIN_CSN] & r.lvl[PIN_CSN];
    mk_tx = n.lvl[PIN_TXM];
    mk_rx = n.lvl[PIN_RXM];
    tx_slot = r.nd ? 6'h00 : r.tx_cur.slot;
    rx_slot = r.nd ? 6'h00 : r.rx_cur.slot;
    bitv = 1'b0;
    if (b_rise) begin
      // frame starts count down pending assignments
      if (r.nd ? (mk_tx && !r.txc.mk) : r.txc.pend) begin
        if (r.tx_wait == 2'h2) begin
          n.tx_wait = 2'h1;
        end else if (r.tx_wait == 2'h1) begin
          n.tx_cur = r.tx_new;
          n.tx_wait = 2'h0;
        end
      end
      if (r.nd ? (mk_rx && !r.rxc.mk) : r.rxc.pend) begin
        if (r.rx_wait == 2'h2) begin
          n.rx_wait = 2'h1;
        end else if (r.rx_wait == 2'h1) begin
          n.rx_cur = r.rx_new;
          n.rx_wait = 2'h0;
        end
      end
      tx_slot = r.nd ? 6'h00 : n.tx_cur.slot; // assignment starting at this frame
      n.txc = cnt_step(r.txc, mk_tx, r.nd);
      n.rxc = cnt_step(r.rxc, mk_rx, r.nd);
      // transmit bit driven only in the assigned slot, or in slot 0 under non-delayed timing
      if (n.txc.act && n.txc.slot == tx_slot && n.tx_cur.en) begin
        bitv = (n.txc.bitc == 3'h0) ? tx_sample[7] : r.txsh[7];
        n.txsh = (n.txc.bitc == 3'h0) ? {tx_sample[6:0], 1'b0} : {r.txsh[6:0], 1'b0};
        n.taken = (n.txc.bitc == 3'h0);
        n.dx0 = bitv;
        n.dx1 = bitv;
        n.dx0_oe = !n.tx_cur.port;
        n.dx1_oe = n.tx_cur.port;
      end else begin
        n.dx0_oe = 1'b0;
        n.dx1_oe = 1'b0;
      end
    end
    // receive bit sampled on the falling edge in the assigned slot, or in slot 0 under non-delayed timing
    if (b_fall && r.rxc.act && r.rxc.slot == rx_slot && r.rx_cur.en) begin
      bitv = r.rx_cur.port ? n.lvl[PIN_RD1] : n.lvl[PIN_RD0];
      n.rxsh = {r.rxsh[6:0], bitv};
      if (r.rxc.bitc == SLOT_LAST_BIT) begin
        n.rxb = {r.rxsh[6:0], bitv};
        n.rxv = 1'b1;
      end
    end
    // serial control port shift-in
    if (s_fall) begin
      n.nbit = 5'h00;
    end
    if (c_rise && !n.lvl[PIN_CSN]) begin
      n.ins = {r.ins[14:0], n.lvl[PIN_CDAT]};
      if (r.nbit != 5'h1f) begin
        n.nbit = r.nbit + 5'h01;
      end
    end
    // instruction takes effect on select release after exactly 16 bits
    if (s_rise && r.nbit == INSTR_BITS) begin
      case (r.ins[15:8])
        CMD_TIMING: n.nd = r.ins[TIM_ND];
        CMD_TX_ASSIGN: begin
          n.tx_new = to_asg(r.ins[7:0]);
          n.tx_wait = 2'h2;
        end
        CMD_RX_ASSIGN: begin
          n.rx_new = to_asg(r.ins[7:0]);
          n.rx_wait = 2'h2;
        end
        CMD_TX_GAIN: begin
          n.txg = r.ins[7:0];
          n.txg_off = (r.ins[7:0] == 8'h00);
        end
        CMD_RX_GAIN: begin
          n.rxg = r.ins[7:0];
          n.rxg_off = (r.ins[7:0] == 8'h00);
        end
        CMD_HYB_ONE: begin
          n.hyb = r.ins[7:0];
          n.att = (r.ins[4:0] > ATTEN_MAX) ? ATTEN_MAX : r.ins[4:0];
        end
        CMD_HYB_TWO: begin
          n.low = r.ins[7:0];
          n.low_on = (r.ins[7:0] != 8'h00);
        end
        default: ;
      endcase
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.p0 <= 8'h40;
      r.p1 <= 8'h40;
      r.p2 <= 8'h40;
      r.lvl <= 8'h40; // select idles high
      r.nd <= TIMING_ND_RST;
      r.txg <= GAIN_RST;
      r.rxg <= GAIN_RST;
      r.txg_off <= (GAIN_RST == 8'h00);
      r.rxg_off <= (GAIN_RST == 8'h00);
      r.hyb <= HYB_RST;
      r.low <= LOW_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  assign link.tx_pcm_out_first_o = r.dx0;
  assign link.tx_pcm_out_first_oe = r.dx0_oe;
  assign link.tx_pcm_out_second_o = r.dx1;
  assign link.tx_pcm_out_second_oe = r.dx1_oe;
  assign tx_sample_taken = r.taken;
  assign rx_sample = r.rxb;
  assign rx_sample_valid = r.rxv;
  assign nondelayed_timing = r.nd;
  assign tx_level_code = r.txg;
  assign tx_muted = r.txg_off;
  assign rx_level_code = r.rxg;
  assign analog_rx_off = r.rxg_off;
  assign echo_enable = r.hyb[HYB_EN];
  assign echo_phase_noninv = r.hyb[HYB_PHASE];
  assign high_band_insert = r.hyb[HYB_HIGH];
  assign cancel_attenuation = r.att;
  assign low_band_enable = r.low_on;
  assign low_band_first_order = r.low[LOW_MODE];
  assign low_band_pz = r.low[6:0];
endmodule : psg_codec_end

// file: core/psg_ctrl_end.sv
// controller end: ahb-lite registers, highway timing and serial instruction sender
module psg_ctrl_end
  import psg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  psg_link_if.ctrl link
);
  typedef struct packed {
    logic ap, rdy;
    logic [7:0] ap_addr;
    logic [31:0] rdat;
    logic run, ndf, busy;
    logic rx_en, rx_port, mon_port;
    logic [5:0] rx_slot, mon_slot;
    logic [7:0] rx_byte, mon_byte, mon_sh, frames;
    logic [3:0] div, cdiv;
    logic bclk, txm, rxm, rd0, rd1;
    logic [8:0] pos;
    psg_cstate_t cst;
    logic cclk, csn, cdat;
    logic [15:0] csh;
    logic [4:0] cbit;
    logic [1:0] q0, q1, q2, ql;
  } psg_ctrl_st_t;

  psg_ctrl_st_t r, n;
  logic [8:0] posn;
  logic mbit, hit;

  // register read mux
  function automatic logic [31:0] rd_mux(input psg_ctrl_st_t s, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0;
    if (a == REG_CTRL) begin
      d = {30'h0, s.ndf, s.run};
    end else if (a == REG_CMD) begin
      d = {16'h0, s.csh};
    end else if (a == REG_STATUS) begin
      d = {16'h0, s.frames, 7'h0, s.busy};
    end else if (a == REG_RX_SRC) begin
      d = {16'h0, s.rx_byte, s.rx_en, s.rx_port, s.rx_slot};
    end else if (a == REG_TX_MON) begin
      d = {16'h0, s.mon_byte, 1'b0, s.mon_port, s.mon_slot};
    end
    return d;
  endfunction : rd_mux

  // next state
  always_comb begin
    n = r;
    posn = r.pos + 9'h001;
    mbit = 1'b1;
    hit = 1'b0;
    // bus data phase of a write
    if (r.ap) begin
      if (r.ap_addr == REG_CTRL) begin
        n.run = hwdata[CTRL_RUN];
        n.ndf = hwdata[CTRL_ND]; // keep clear when assignment is used
      end else if (r.ap_addr == REG_CMD && !r.busy) begin
        n.csh = hwdata[15:0]; // codes come ready from software
        if (!DUAL_PORT && (hwdata[15:8] == CMD_TX_ASSIGN || hwdata[15:8] == CMD_RX_ASSIGN)) begin
          n.csh[ASG_PORT] = 1'b0;
        end
        n.busy = 1'b1;
        n.cst = C_SETUP;
        n.cdiv = 4'h0;
        n.csn = 1'b0;
      end else if (r.ap_addr == REG_RX_SRC) begin
        n.rx_slot = hwdata[5:0];
        n.rx_port = hwdata[6];
        n.rx_en = hwdata[7];
        n.rx_byte = hwdata[15:8];
      end else if (r.ap_addr == REG_TX_MON) begin
        n.mon_slot = hwdata[5:0];
        n.mon_port = hwdata[6];
      end
    end
    // bus address phase
    n.ap = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.ap = hwrite;
      n.ap_addr = haddr[7:0];
      if (!hwrite) begin
        n.rdat = rd_mux(r, haddr[7:0]);
      end
    end
    // synchronise the returning transmit lines
    n.q0 = {link.tx_pcm_out_second, link.tx_pcm_out_first};
    n.q1 = r.q0;
    n.q2 = r.q1;
    n.ql = (r.q1 & r.q2) | (r.ql & (r.q1 ^ r.q2));
    // highway timing
    if (!r.run) begin
      n.bclk = 1'b0;
      n.div = 4'h0;
      n.txm = 1'b0;
      n.rxm = 1'b0;
    end else if (r.div != HALF_LAST) begin
      n.div = r.div + 4'h1;
    end else begin
      n.div = 4'h0;
      n.bclk = !r.bclk;
      if (!r.bclk) begin
        // end of bit period: capture monitored slot, then next bit
        if (r.pos[8:3] == r.mon_slot) begin
          mbit = r.mon_port ? r.ql[1] : r.ql[0];
          n.mon_sh = {r.mon_sh[6:0], mbit};
          if (r.pos[2:0] == SLOT_LAST_BIT) begin
            n.mon_byte = {r.mon_sh[6:0], mbit};
          end
        end
        n.pos = posn;
        if (posn == 9'h000) begin
          n.frames = r.frames + 8'h01;
        end
        hit = r.rx_en && posn[8:3] == r.rx_slot;
        mbit = r.rx_byte[3'h7 - posn[2:0]]; // msb first
        n.rd0 = !(hit && !r.rx_port) | mbit;
        n.rd1 = !(hit && r.rx_port) | mbit;
      end else begin
        // markers change mid-period so they are stable at the next rise
        n.txm = r.ndf ? (r.pos == FRAME_LAST) : (r.pos == FRAME_LAST - 9'h001);
        n.rxm = n.txm;
      end
    end
    // serial instruction sender
    if (r.cst != C_IDLE) begin
      if (r.cdiv != HALF_LAST) begin
        n.cdiv = r.cdiv + 4'h1;
      end else begin
        n.cdiv = 4'h0;
        case (r.cst)
          C_SETUP: begin
            n.cdat = r.csh[15];
            n.cst = C_LOW;
          end
          C_LOW: begin
            n.cclk = 1'b1;
            n.cst = C_HIGH;
          end
          C_HIGH: begin
            n.cclk = 1'b0;
            n.csh = {r.csh[14:0], 1'b0};
            n.cdat = r.csh[14];
            n.cbit = r.cbit + 5'h01;
            n.cst = (r.cbit == INSTR_BITS - 5'h01) ? C_HOLD : C_LOW;
          end
          C_HOLD: begin
            n.csn = 1'b1;
            n.busy = 1'b0;
            n.cbit = 5'h00;
            n.cst = C_IDLE;
          end
          default: n.cst = C_IDLE;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.rdy <= 1'b1;
      r.csn <= 1'b1;
      r.rd0 <= 1'b1;
      r.rd1 <= 1'b1;
      r.pos <= FRAME_LAST;
      r.cst <= C_IDLE;
    end else if (ce) begin
      r <= n;
    end
  end

  assign hrdata = r.rdat;
  assign hreadyout = r.rdy;
  assign hresp = 1'b0 & r.rdy;
  assign link.bclk = r.bclk;
  assign link.tx_frame_marker = r.txm;
  assign link.rx_frame_marker = r.rxm;
  assign link.rx_pcm_in_first = r.rd0;
  assign link.rx_pcm_in_second = r.rd1;
  assign link.ctrl_clk = r.cclk;
  assign link.ctrl_sel_n = r.csn;
  assign link.ctrl_data = r.cdat;
endmodule : psg_ctrl_end

// file: core/psg_link_if.sv
// pcm highway and serial control wires between controller and codec
interface psg_link_if;
  logic bclk;
  logic tx_frame_marker;
  logic rx_frame_marker;
  logic rx_pcm_in_first;
  logic rx_pcm_in_second;
  logic tx_pcm_out_first_o;
  logic tx_pcm_out_first_oe;
  logic tx_pcm_out_second_o;
  logic tx_pcm_out_second_oe;
  logic tx_pcm_out_first;
  logic tx_pcm_out_second;
  logic ctrl_clk;
  logic ctrl_sel_n;
  logic ctrl_data;
  // shared highway lines idle high when nobody drives
  assign tx_pcm_out_first = tx_pcm_out_first_oe ? tx_pcm_out_first_o : 1'b1;
  assign tx_pcm_out_second = tx_pcm_out_second_oe ? tx_pcm_out_second_o : 1'b1;
  modport codec (
    input bclk, tx_frame_marker, rx_frame_marker, rx_pcm_in_first, rx_pcm_in_second,
    input ctrl_clk, ctrl_sel_n, ctrl_data,
    output tx_pcm_out_first_o, tx_pcm_out_first_oe, tx_pcm_out_second_o, tx_pcm_out_second_oe
  );
  modport ctrl (
    output bclk, tx_frame_marker, rx_frame_marker, rx_pcm_in_first, rx_pcm_in_second,
    output ctrl_clk, ctrl_sel_n, ctrl_data,
    input tx_pcm_out_first, tx_pcm_out_second
  );
endinterface : psg_link_if

// file: core/psg_pkg.sv
// shared constants and types for the slot, gain and echo-cancel configuration link
package psg_pkg;
  // clock rate and link half period
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned LINK_HALF_NS = 200;
  localparam int unsigned LINK_HALF_CYC = LINK_HALF_NS * CLK_MHZ / 1000;
  localparam logic [3:0] HALF_LAST = 4'(LINK_HALF_CYC - 1);
  // frame geometry
  localparam logic [2:0] SLOT_LAST_BIT = 3'h7;
  localparam logic [5:0] SLOT_LAST = 6'h3f;
  localparam logic [8:0] FRAME_LAST = 9'h1ff;
  localparam logic [4:0] INSTR_BITS = 5'h10;
  localparam logic DUAL_PORT = 1'b1;
  // instruction codes, first byte
  localparam logic [7:0] CMD_TIMING = 8'h01;
  localparam logic [7:0] CMD_TX_ASSIGN = 8'h02;
  localparam logic [7:0] CMD_RX_ASSIGN = 8'h03;
  localparam logic [7:0] CMD_TX_GAIN = 8'h04;
  localparam logic [7:0] CMD_RX_GAIN = 8'h05;
  localparam logic [7:0] CMD_HYB_ONE = 8'h06;
  localparam logic [7:0] CMD_HYB_TWO = 8'h07;
  // second byte field positions
  localparam int unsigned ASG_EN = 7;
  localparam int unsigned ASG_PORT = 6;
  localparam int unsigned TIM_ND = 3;
  localparam int unsigned HYB_EN = 7;
  localparam int unsigned HYB_PHASE = 6;
  localparam int unsigned HYB_HIGH = 5;
  localparam int unsigned LOW_MODE = 7;
  localparam logic [4:0] ATTEN_MAX = 5'h18;
  // reset values
  localparam logic TIMING_ND_RST = 1'b1;
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [7:0] HYB_RST = 8'h00;
  localparam logic [7:0] LOW_RST = 8'h00;
  // pin indices in the codec input vector
  localparam int unsigned PIN_BCLK = 0;
  localparam int unsigned PIN_TXM = 1;
  localparam int unsigned PIN_RXM = 2;
  localparam int unsigned PIN_RD0 = 3;
  localparam int unsigned PIN_RD1 = 4;
  localparam int unsigned PIN_CCLK = 5;
  localparam int unsigned PIN_CSN = 6;
  localparam int unsigned PIN_CDAT = 7;
  // controller register offsets and bits
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RX_SRC = 8'h0c;
  localparam logic [7:0] REG_TX_MON = 8'h10;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_ND = 1;
  // slot counter of one direction
  typedef struct packed {
    logic act;
    logic pend;
    logic mk;
    logic [2:0] bitc;
    logic [5:0] slot;
  } psg_cnt_t;
  // one slot assignment
  typedef struct packed {
    logic en;
    logic port;
    logic [5:0] slot;
  } psg_asg_t;
  typedef enum logic [2:0] {C_IDLE, C_SETUP, C_LOW, C_HIGH, C_HOLD} psg_cstate_t;
endpackage : psg_pkg

// file: tb/psg_link_checker.sv
// link checker: highway, slot and control-port timing between the two ends
module psg_link_checker
  import psg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic bclk,
  input wire logic tx_frame_marker,
  input wire logic rx_frame_marker,
  input wire logic tx_pcm_out_first_o,
  input wire logic tx_pcm_out_first_oe,
  input wire logic tx_pcm_out_second_oe,
  input wire logic ctrl_clk,
  input wire logic ctrl_sel_n,
  input wire logic ctrl_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bclk_q;
  logic cclk_q;
  logic [3:0] oe_cnt;
  logic [4:0] bit_cnt;
  wire logic oe_any = tx_pcm_out_first_oe | tx_pcm_out_second_oe;
  // bit clock rises inside a driven slot, control clock rises inside a select frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bclk_q <= 1'b0;
      cclk_q <= 1'b0;
      oe_cnt <= 4'h0;
      bit_cnt <= 5'h00;
    end else begin
      bclk_q <= bclk;
      cclk_q <= ctrl_clk;
      if (!oe_any) oe_cnt <= 4'h0;
      else if (bclk && !bclk_q && oe_cnt != 4'hf) oe_cnt <= oe_cnt + 4'h1;
      if (ctrl_sel_n) bit_cnt <= 5'h00;
      else if (ctrl_clk && !cclk_q) bit_cnt <= bit_cnt + 5'h01;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  one_port_a: assert property (!(tx_pcm_out_first_oe && tx_pcm_out_second_oe))
    else $error("both transmit ports driven");
  slot_max_a: assert property (oe_cnt <= 4'h8)
    else $error("transmit slot longer than eight bits");
  slot_exact_a: assert property ($fell(oe_any) |-> oe_cnt == 4'h8)
    else $error("transmit slot not eight bits");
  marker_width_a: assert property ($rose(tx_frame_marker) |->
    tx_frame_marker [*8] ##1 tx_frame_marker [*8] ##1 !tx_frame_marker)
    else $error("frame marker not one bit period");
  markers_same_a: assert property (tx_frame_marker == rx_frame_marker)
    else $error("frame markers differ");
  bclk_half_a: assert property ($rose(bclk) |-> bclk [*8] ##1 !bclk)
    else $error("bit clock half period wrong");
  tx_bit_hold_a: assert property (
    tx_pcm_out_first_oe && $changed(tx_pcm_out_first_o) |=> $stable(tx_pcm_out_first_o) [*8])
    else $error("transmit bit too short");
  sel_lead_a: assert property ($fell(ctrl_sel_n) |-> !ctrl_clk [*8])
    else $error("control clock too soon after select");
  data_hold_a: assert property (ctrl_clk |-> $stable(ctrl_data))
    else $error("control data moved while clock high");
  bit_count_a: assert property ($rose(ctrl_sel_n) |-> bit_cnt == INSTR_BITS)
    else $error("instruction not sixteen bits");
endmodule : psg_link_checker

// file: tb/tb.sv
// testbench: both link ends joined, ahb driver and result monitor
module tb
  import psg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] tx_sample = 8'h00;
  logic [7:0] rx_sample;
  logic rx_valid;
  logic taken;
  logic note_rd = 1'b0;
  logic rd_dp = 1'b0;
  logic snap = 1'b0;
  logic rx_strict = 1'b0;
  wire [35:0] cfg;
  logic [35:0] q_cfg[$];
  logic [31:0] q_rd[$];
  logic [7:0] q_rx[$];
  logic [31:0] rs = 32'h1b;
  logic [31:0] dmy;
  logic [7:0] tg, rg, h1, h2;
  logic nd;
  int error_cnt = 0;
  int tests_run = 0;
  int taken_cnt = 0;
  psg_link_if link_if ();
  psg_ctrl_end psg_ctrl_end_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link_if));
  psg_codec_end psg_codec_end_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .link(link_if),
    .tx_sample(tx_sample), .tx_sample_taken(taken), .rx_sample(rx_sample),
    .rx_sample_valid(rx_valid),
    .nondelayed_timing(cfg[35]), .tx_level_code(cfg[34:27]), .tx_muted(cfg[26]),
    .rx_level_code(cfg[25:18]), .analog_rx_off(cfg[17]), .echo_enable(cfg[16]),
    .echo_phase_noninv(cfg[15]), .high_band_insert(cfg[14]), .cancel_attenuation(cfg[13:9]),
    .low_band_enable(cfg[8]), .low_band_first_order(cfg[7]), .low_band_pz(cfg[6:0]));
  psg_link_checker psg_link_checker_inst (.hclk(hclk), .hresetn(hresetn), .bclk(link_if.bclk),
    .tx_frame_marker(link_if.tx_frame_marker), .rx_frame_marker(link_if.rx_frame_marker),
    .tx_pcm_out_first_o(link_if.tx_pcm_out_first_o),
    .tx_pcm_out_first_oe(link_if.tx_pcm_out_first_oe),
    .tx_pcm_out_second_oe(link_if.tx_pcm_out_second_oe), .ctrl_clk(link_if.ctrl_clk),
    .ctrl_sel_n(link_if.ctrl_sel_n), .ctrl_data(link_if.ctrl_data));
  // 40 mhz clock
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs
  // expected codec settings from the shadow copies
  function automatic logic [35:0] cfg_exp();
    logic [4:0] a;
    a = (h1[4:0] > ATTEN_MAX) ? ATTEN_MAX : h1[4:0];
    return {nd, tg, tg == 8'h00, rg, rg == 8'h00, h1[7:5], a, h2 != 8'h00, h2};
  endfunction : cfg_exp
  task automatic cmp(input string nm, input logic [35:0] e, input logic [35:0] g);
    tests_run++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : cmp
  // one single ahb transfer, address phase then data phase
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic chk,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    note_rd <= chk;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    r = hrdata;
  endtask : ahb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    ahb(a, 1'b0, 32'h0, 1'b1, dmy);
  endtask : rd_chk
  // hand one instruction to the sender and wait until it is out
  task automatic send(input logic [7:0] c, input logic [7:0] d);
    logic [31:0] st;
    ahb(REG_CMD, 1'b1, {16'h0, c, d}, 1'b0, st);
    repeat (2) @(posedge hclk);
    // only the watchdog ends a hung sender
    do begin
      ahb(REG_STATUS, 1'b0, 32'h0, 1'b0, st);
    end while (st[0] !== 1'b0);
    repeat (8) @(posedge hclk);
  endtask : send
  task automatic snap_cfg();
    q_cfg.push_back(cfg_exp());
    snap <= 1'b1;
    @(posedge hclk);
    snap <= 1'b0;
    @(posedge hclk);
  endtask : snap_cfg
  task automatic wait_frame(input logic [7:0] f);
    logic [31:0] st;
    do begin
      ahb(REG_STATUS, 1'b0, 32'h0, 1'b0, st);
    end while (st[15:8] !== f);
  endtask : wait_frame
  // assign both directions to slot s on port p, then watch traffic both ways
  task automatic hw_case(input logic p, input logic [5:0] s, input logic quiet);
    logic [7:0] rb;
    logic [7:0] tb_b;
    logic [7:0] f;
    int t0;
    logic [31:0] st;
    rb = 8'(xs());
    tb_b = 8'(xs()) & 8'hfe;
    ahb(REG_RX_SRC, 1'b1, {16'h0, rb, 1'b1, p, s}, 1'b0, st);
    ahb(REG_TX_MON, 1'b1, {24'h0, 1'b0, p, s}, 1'b0, st);
    tx_sample <= tb_b;
    rx_strict <= quiet;
    send(CMD_TX_ASSIGN, {1'b1, p, s});
    send(CMD_RX_ASSIGN, {1'b1, p, s});
    ahb(REG_STATUS, 1'b0, 32'h0, 1'b0, st);
    f = st[15:8];
    wait_frame(f + 8'h02);
    q_rx.push_back(rb);
    t0 = taken_cnt;
    rx_strict <= 1'b1;
    wait_frame(f + 8'h03);
    rx_strict <= 1'b0;
    cmp("tx_sample_taken", 36'h1, 36'(taken_cnt - t0));
    cmp("rx notes left", 36'h0, {4'h0, 32'(q_rx.size())});
    rd_chk(REG_TX_MON, {16'h0, tb_b, 1'b0, p, s});
  endtask : hw_case
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // monitor: each result that appears takes the oldest note
  always @(posedge hclk) begin
    if (rd_dp) cmp("hrdata", {4'h0, q_rd.pop_front()}, {3'h0, hresp, hrdata});
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout && note_rd;
    if (taken) taken_cnt++;
    if (snap) cmp("codec settings", q_cfg.pop_front(), cfg);
    if (rx_valid && q_rx.size() > 0) begin
      cmp("rx_sample", {28'h0, q_rx.pop_front()}, {28'h0, rx_sample});
    end else if (rx_valid && rx_strict) begin
      cmp("rx_sample_valid", 36'h0, 36'h1);
    end
  end
  // about 60k cycles of tests, cut off well past that
  initial begin
    repeat (95000) @(posedge hclk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    {tg, rg, h1, h2, nd} = {32'h0, 1'b1};
    snap_cfg();
    rd_chk(REG_CTRL, 32'h0);
    ahb(8'h24, 1'b1, 32'hffffffff, 1'b0, dmy);
    rd_chk(8'h24, 32'h0);
    ahb(REG_CTRL, 1'b1, 32'h3, 1'b0, dmy);
    rd_chk(REG_CTRL, 32'h3);
    // gains, echo-cancel bytes and timing, with boundary codes
    for (int i = 0; i < 6; i++) begin
      tg = (i == 0) ? 8'h00 : 8'(xs());
      rg = (i == 1) ? 8'h00 : 8'(xs());
      h1 = (i == 0) ? 8'hf8 : (i == 1) ? 8'h19 : 8'(xs());
      h2 = (i == 2) ? 8'h00 : 8'(xs());
      nd = i[0];
      send(CMD_TIMING, {4'h0, nd, 3'h0});
      send(CMD_TX_GAIN, tg);
      send(CMD_RX_GAIN, rg);
      send(CMD_HYB_ONE, h1);
      send(CMD_HYB_TWO, h2);
      snap_cfg();
    end
    send(8'h3f, 8'h55);
    nd = 1'b0;
    send(CMD_TIMING, 8'h00);
    snap_cfg();
    ahb(REG_CTRL, 1'b1, 32'h1, 1'b0, dmy);
    hw_case(1'b0, 6'(xs()), 1'b1);
    hw_case(1'b1, SLOT_LAST, 1'b0);
    print_verdict();
  end
endmodule : tb
